// >>> include/tod_pkg.sv
// Purpose : shared constants and types of the transfer op-code decoder
// Assumes : one clock domain, bytes delivered by the fetch unit
// Notes   : op-code groups are matched on upper bits, mode on lower bits
`default_nettype none

package tod_pkg;

  // escape and special first bytes
  localparam logic [7:0] OP_ESC_EXT   = 8'hCE;
  localparam logic [7:0] OP_ESC_WIDE  = 8'hCF;
  localparam logic [7:0] OP_ABS8_IMM  = 8'hDD;
  // second op-codes after the extended escape
  localparam logic [7:0] OP_RD_BASE   = 8'hC0;
  localparam logic [7:0] OP_RD_FLAGS  = 8'hC1;
  localparam logic [5:0] GRP_RD_PAGE  = 6'h32;
  localparam logic [5:0] GRP_ABS16    = 6'h34;
  // rows of 8-bit loads into the three data registers (40, 48, 50)
  localparam logic [4:0] GRP_ROW_FIRST = 5'h08;
  localparam logic [4:0] GRP_ROW_LAST  = 5'h0A;
  localparam logic [5:0] GRP_IMM8      = 6'h2C;

  // low op-code bits that select the addressing mode
  localparam logic [2:0] MODE_ABS8    = 3'h4;
  localparam logic [2:0] MODE_PTR     = 3'h5;
  localparam logic [2:0] MODE_IX1     = 3'h6;
  localparam logic [2:0] MODE_IX2     = 3'h7;
  localparam logic [2:0] MODE_DISP1   = 3'h0;
  localparam logic [2:0] MODE_DISP2   = 3'h1;
  localparam logic [2:0] MODE_LOW1    = 3'h2;
  localparam logic [2:0] MODE_LOW2    = 3'h3;

  // bus cycles per form
  localparam logic [2:0] CYC_REG      = 3'h1;
  localparam logic [2:0] CYC_IMM8     = 3'h2;
  localparam logic [2:0] CYC_ABS8     = 3'h3;
  localparam logic [2:0] CYC_ABS8_IMM = 3'h4;
  localparam logic [2:0] CYC_ABS16    = 3'h5;
  localparam logic [2:0] CYC_IND      = 3'h2;
  localparam logic [2:0] CYC_DISP     = 3'h4;
  localparam logic [2:0] CYC_LOW      = 3'h4;
  localparam logic [2:0] CYC_SYSREG   = 3'h2;

  localparam logic [2:0] LEN_MIN      = 3'h1;
  localparam logic [2:0] LEN_MAX      = 3'h4;
  localparam logic [1:0] DEST_MEM     = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SECOND = 3'b001,
    ST_OPND1  = 3'b011,
    ST_OPND2  = 3'b010,
    ST_ISSUE  = 3'b110
  } tod_state_t;

  typedef enum logic [1:0] {
    ESC_NONE = 2'h0,
    ESC_EXT  = 2'h1,
    ESC_WIDE = 2'h2
  } tod_esc_t;

  typedef enum logic [3:0] {
    FORM_NONE     = 4'h0,
    FORM_REG      = 4'h1,
    FORM_IMM8     = 4'h2,
    FORM_ABS8     = 4'h3,
    FORM_ABS8_IMM = 4'h4,
    FORM_ABS16    = 4'h5,
    FORM_IND_PTR  = 4'h6,
    FORM_IND_IX1  = 4'h7,
    FORM_IND_IX2  = 4'h8,
    FORM_DISP_IX1 = 4'h9,
    FORM_DISP_IX2 = 4'hA,
    FORM_LOW_IX1  = 4'hB,
    FORM_LOW_IX2  = 4'hC,
    FORM_SYSREG   = 4'hD
  } tod_form_t;

endpackage : tod_pkg

`default_nettype wire

// >>> src/tod_addr_gen.sv
// Purpose : forms the 24-bit data address (page, high, low) of a load
// Assumes : register values are stable while the decoder issues
// Notes   : purely combinational, the caller registers the result
`default_nettype none

module tod_addr_gen
  import tod_pkg::*;
(
  input  wire tod_pkg::tod_form_t i_form,
  input  wire logic [15:0]        i_opnd,
  input  wire logic [7:0]         i_base,
  input  wire logic [15:0]        i_ptr,
  input  wire logic [15:0]        i_ix1,
  input  wire logic [15:0]        i_ix2,
  input  wire logic [7:0]         i_low,
  input  wire logic [7:0]         i_gen_page,
  input  wire logic [7:0]         i_ix1_page,
  input  wire logic [7:0]         i_ix2_page,
  input  wire logic               i_large,
  output logic      [23:0]        o_ea
);

  logic [15:0] disp;
  logic [15:0] offs;
  logic [7:0]  page;

  ///////////////////////////////////////////////////////////////////////////
  always_comb begin
    disp = {{8{i_opnd[7]}}, i_opnd[7:0]};
    offs = {{8{i_low[7]}}, i_low};
    page = 8'h00;
    o_ea = 24'h000000;
    case (i_form)
      FORM_ABS8, FORM_ABS8_IMM: begin
        page = i_gen_page;
        o_ea = {8'h00, i_base, i_opnd[7:0]};
      end
      FORM_ABS16: begin
        page = i_gen_page;
        o_ea = {8'h00, i_opnd};
      end
      FORM_IND_PTR: begin
        page = i_gen_page;
        o_ea = {8'h00, i_ptr};
      end
      FORM_IND_IX1: begin
        page = i_ix1_page;
        o_ea = {8'h00, i_ix1};
      end
      FORM_IND_IX2: begin
        page = i_ix2_page;
        o_ea = {8'h00, i_ix2};
      end
      FORM_DISP_IX1: begin
        page = i_ix1_page;
        o_ea = {8'h00, 16'(i_ix1 + disp)};
      end
      FORM_DISP_IX2: begin
        page = i_ix2_page;
        o_ea = {8'h00, 16'(i_ix2 + disp)};
      end
      FORM_LOW_IX1: begin
        page = i_ix1_page;
        o_ea = {8'h00, 16'(i_ix1 + offs)};
      end
      FORM_LOW_IX2: begin
        page = i_ix2_page;
        o_ea = {8'h00, 16'(i_ix2 + offs)};
      end
      default: begin
        page = 8'h00;
        o_ea = 24'h000000;
      end
    endcase
    if (i_large) begin
      o_ea[23:16] = page;
    end
  end

endmodule : tod_addr_gen

`default_nettype wire

// >>> src/tod_decoder.sv
// Purpose : decodes 8-bit load instructions byte by byte from the fetch unit
// Assumes : one byte per cycle at most, taken whenever O_READY is high
// Notes   : other instruction classes are reported as unsupported
//
// Summary of operation
// - instructions span one to four bytes, op-codes and operands.
// - first byte CE or CF escapes; next byte is the real op-code.
// - CF reaches 16-bit and stack groups; CE reaches all other extensions.
// - addressing mode comes from low three bits of defining op-code.
// - register, indirect and index-plus-low forms fetch no operand byte.
// - immediate, displacement, short absolute forms take one raw operand.
// - two-byte operands arrive low byte first, then high byte.
// - short absolute with immediate: address byte first, value second.
// - register loads 40/48/50 rows, source by low bits, one cycle.
// - B0, B1, B2 load immediate value; two cycles, two bytes.
// - 44, 4C, 54 load via base register upper byte; three cycles.
// - CE D0..D2 load from full address; five cycles, four bytes.
// - 45, 46, 47 style codes load through pointers; two cycles.
// - CE 40/41 style take signed displacement; four cycles, three bytes.
// - CE 42/43 style index plus low register; four cycles, two bytes.
// - bank and page register access is invalid in small models.
// - these loads never alter the system condition flags.
// - large models take page from general or per-index page register.
// - low register offset is sign-extended before index addition.
`default_nettype none

module tod_decoder
  import tod_pkg::*;
(
  input  wire logic              I_CLK,
  input  wire logic              I_RESET_N,
  input  wire logic              I_BYTE_VALID,
  input  wire logic [7:0]        I_BYTE,
  input  wire logic              I_LARGE_MODEL,
  input  wire logic [7:0]        I_BASE_REG,
  input  wire logic [15:0]       I_PTR_PAIR,
  input  wire logic [15:0]       I_INDEX1,
  input  wire logic [15:0]       I_INDEX2,
  input  wire logic [7:0]        I_LOW_DATA,
  input  wire logic [7:0]        I_GEN_PAGE,
  input  wire logic [7:0]        I_IDX1_PAGE,
  input  wire logic [7:0]        I_IDX2_PAGE,
  output logic                   O_READY,
  output logic                   O_PC_ADVANCE,
  output logic                   O_DONE,
  output logic                   O_INVALID,
  output logic                   O_WIDE_GROUP,
  output logic                   O_SC_WRITE,
  output tod_pkg::tod_form_t     O_FORM,
  output logic [1:0]             O_DEST,
  output logic [3:0]             O_SRC,
  output logic [2:0]             O_ADDR_MODE,
  output logic [2:0]             O_LEN,
  output logic [2:0]             O_CYCLES,
  output logic [15:0]            O_OPERAND,
  output logic [23:0]            O_EA
);

  tod_state_t  state_reg;
  tod_state_t  state_next;
  tod_esc_t    esc_reg;
  tod_form_t   form_reg;
  tod_form_t   dec_form;
  logic [1:0]  dec_dest;
  logic [3:0]  dec_src;
  logic [1:0]  dec_nop;
  logic [2:0]  dec_cyc;
  logic        dec_ok;
  logic        dec_big;
  logic [1:0]  dest_reg;
  logic [3:0]  src_reg;
  logic [1:0]  nop_reg;
  logic [2:0]  cyc_reg;
  logic [2:0]  mode_reg;
  logic        ok_reg;
  logic [15:0] opnd_reg;
  logic [2:0]  count_reg;
  logic [23:0] ea;
  logic        take;
  logic        op_stage;

  assign op_stage = (state_reg == ST_IDLE) || (state_reg == ST_SECOND);
  assign take = I_BYTE_VALID && (state_reg != ST_ISSUE);

  ///////////////////////////////////////////////////////////////////////////
  // op-code table, addressed by escape and the defining byte
  always_comb begin
    dec_form = FORM_NONE;
    dec_dest = I_BYTE[4:3];
    dec_src  = {2'h0, I_BYTE[1:0]};
    dec_nop  = 2'h0;
    dec_cyc  = CYC_REG;
    dec_ok   = 1'b0;
    dec_big  = 1'b0;
    case (esc_reg)
      ESC_NONE: begin
        if (I_BYTE[7:3] >= GRP_ROW_FIRST && I_BYTE[7:3] <= GRP_ROW_LAST) begin
          dec_ok = 1'b1;
          case (I_BYTE[2:0])
            MODE_ABS8: begin
              dec_form = FORM_ABS8;
              dec_nop  = 2'h1;
              dec_cyc  = CYC_ABS8;
            end
            MODE_PTR: begin
              dec_form = FORM_IND_PTR;
              dec_cyc  = CYC_IND;
            end
            MODE_IX1: begin
              dec_form = FORM_IND_IX1;
              dec_cyc  = CYC_IND;
            end
            MODE_IX2: begin
              dec_form = FORM_IND_IX2;
              dec_cyc  = CYC_IND;
            end
            default: begin
              dec_form = FORM_REG;
              dec_cyc  = CYC_REG;
            end
          endcase
        end else if (I_BYTE[7:2] == GRP_IMM8 && I_BYTE[1:0] != 2'h3) begin
          dec_ok   = 1'b1;
          dec_form = FORM_IMM8;
          dec_dest = I_BYTE[1:0];
          dec_nop  = 2'h1;
          dec_cyc  = CYC_IMM8;
        end else if (I_BYTE == OP_ABS8_IMM) begin
          dec_ok   = 1'b1;
          dec_form = FORM_ABS8_IMM;
          dec_dest = DEST_MEM;
          dec_nop  = 2'h2;
          dec_cyc  = CYC_ABS8_IMM;
        end
      end
      ESC_EXT: begin
        if (I_BYTE[7:3] >= GRP_ROW_FIRST && I_BYTE[7:3] <= GRP_ROW_LAST) begin
          dec_ok = 1'b1;
          case (I_BYTE[2:0])
            MODE_DISP1: begin
              dec_form = FORM_DISP_IX1;
              dec_nop  = 2'h1;
              dec_cyc  = CYC_DISP;
            end
            MODE_DISP2: begin
              dec_form = FORM_DISP_IX2;
              dec_nop  = 2'h1;
              dec_cyc  = CYC_DISP;
            end
            MODE_LOW1: begin
              dec_form = FORM_LOW_IX1;
              dec_cyc  = CYC_LOW;
            end
            MODE_LOW2: begin
              dec_form = FORM_LOW_IX2;
              dec_cyc  = CYC_LOW;
            end
            default: begin
              dec_ok = 1'b0;
            end
          endcase
        end else if (I_BYTE[7:2] == GRP_ABS16 && I_BYTE[1:0] != 2'h3) begin
          dec_ok   = 1'b1;
          dec_form = FORM_ABS16;
          dec_dest = I_BYTE[1:0];
          dec_nop  = 2'h2;
          dec_cyc  = CYC_ABS16;
        end else if (I_BYTE == OP_RD_BASE || I_BYTE == OP_RD_FLAGS) begin
          dec_ok   = 1'b1;
          dec_form = FORM_SYSREG;
          dec_dest = 2'h0;
          dec_src  = I_BYTE[3:0];
          dec_cyc  = CYC_SYSREG;
        end else if (I_BYTE[7:2] == GRP_RD_PAGE) begin
          dec_ok   = 1'b1;
          dec_big  = 1'b1;
          dec_form = FORM_SYSREG;
          dec_dest = 2'h0;
          dec_src  = I_BYTE[3:0];
          dec_cyc  = CYC_SYSREG;
        end
      end
      default: begin
        dec_ok = 1'b0;
      end
    endcase
  end

  ///////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (take) begin
          if (I_BYTE == OP_ESC_EXT || I_BYTE == OP_ESC_WIDE) begin
            state_next = ST_SECOND;
          end else if (dec_nop == 2'h0) begin
            state_next = ST_ISSUE;
          end else begin
            state_next = ST_OPND1;
          end
        end
      end
      ST_SECOND: begin
        if (take) begin
          state_next = (dec_nop == 2'h0) ? ST_ISSUE : ST_OPND1;
        end
      end
      ST_OPND1: begin
        if (take) begin
          state_next = (nop_reg == 2'h2) ? ST_OPND2 : ST_ISSUE;
        end
      end
      ST_OPND2: begin
        if (take) begin
          state_next = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      esc_reg <= ESC_NONE;
    end else if (state_reg == ST_IDLE && take) begin
      if (I_BYTE == OP_ESC_EXT) begin
        esc_reg <= ESC_EXT;
      end else if (I_BYTE == OP_ESC_WIDE) begin
        esc_reg <= ESC_WIDE;
      end else begin
        esc_reg <= ESC_NONE;
      end
    end else if (state_reg == ST_ISSUE) begin
      esc_reg <= ESC_NONE;
    end
  end

  ///////////////////////////////////////////////////////////////////////////
  // latch the decode of the defining op-code byte
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      form_reg <= FORM_NONE;
      dest_reg <= 2'h0;
      src_reg  <= 4'h0;
      nop_reg  <= 2'h0;
      cyc_reg  <= 3'h0;
      mode_reg <= 3'h0;
      ok_reg   <= 1'b0;
    end else if (op_stage && take && !(state_reg == ST_IDLE &&
                 (I_BYTE == OP_ESC_EXT || I_BYTE == OP_ESC_WIDE))) begin
      form_reg <= dec_form;
      dest_reg <= dec_dest;
      src_reg  <= dec_src;
      nop_reg  <= dec_nop;
      cyc_reg  <= dec_cyc;
      mode_reg <= I_BYTE[2:0];
      ok_reg   <= dec_ok && (I_LARGE_MODEL || !dec_big);
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      opnd_reg <= 16'h0000;
    end else if (op_stage && take) begin
      opnd_reg <= 16'h0000;
    end else if (state_reg == ST_OPND1 && take) begin
      opnd_reg[7:0] <= I_BYTE;
    end else if (state_reg == ST_OPND2 && take) begin
      opnd_reg[15:8] <= I_BYTE;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      count_reg <= 3'h0;
    end else if (state_reg == ST_ISSUE) begin
      count_reg <= 3'h0;
    end else if (take) begin
      count_reg <= 3'(count_reg + 3'h1);
    end
  end

  tod_addr_gen u_addr_gen (
    .i_form     (form_reg),
    .i_opnd     (opnd_reg),
    .i_base     (I_BASE_REG),
    .i_ptr      (I_PTR_PAIR),
    .i_ix1      (I_INDEX1),
    .i_ix2      (I_INDEX2),
    .i_low      (I_LOW_DATA),
    .i_gen_page (I_GEN_PAGE),
    .i_ix1_page (I_IDX1_PAGE),
    .i_ix2_page (I_IDX2_PAGE),
    .i_large    (I_LARGE_MODEL),
    .o_ea       (ea)
  );

  ///////////////////////////////////////////////////////////////////////////
  // handshake outputs; ready drops for the single issue cycle
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_READY      <= 1'b1;
      O_PC_ADVANCE <= 1'b0;
    end else begin
      O_READY      <= (state_next != ST_ISSUE);
      O_PC_ADVANCE <= take;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_DONE       <= 1'b0;
      O_INVALID    <= 1'b0;
      O_WIDE_GROUP <= 1'b0;
      O_SC_WRITE   <= 1'b0;
      O_FORM       <= FORM_NONE;
      O_DEST       <= 2'h0;
      O_SRC        <= 4'h0;
      O_ADDR_MODE  <= 3'h0;
      O_LEN        <= 3'h0;
      O_CYCLES     <= 3'h0;
      O_OPERAND    <= 16'h0000;
      O_EA         <= 24'h000000;
    end else begin
      O_DONE <= (state_reg == ST_ISSUE);
      O_SC_WRITE <= 1'b0;
      if (state_reg == ST_ISSUE) begin
        O_INVALID    <= !ok_reg;
        O_WIDE_GROUP <= (esc_reg == ESC_WIDE);
        O_FORM       <= ok_reg ? form_reg : FORM_NONE;
        O_DEST       <= dest_reg;
        O_SRC        <= src_reg;
        O_ADDR_MODE  <= mode_reg;
        O_LEN        <= count_reg;
        O_CYCLES     <= ok_reg ? cyc_reg : 3'h0;
        O_OPERAND    <= opnd_reg;
        O_EA         <= ea;
      end
    end
  end

  ///////////////////////////////////////////////////////////////////////////
  len_range_a: assert property (
    @(posedge I_CLK) disable iff (!I_RESET_N)
    O_DONE |-> (O_LEN >= LEN_MIN && O_LEN <= LEN_MAX))
    else $error("instruction length out of range");

  escape_step_a: assert property (
    @(posedge I_CLK) disable iff (!I_RESET_N)
    (state_reg == ST_IDLE && I_BYTE_VALID && I_BYTE == OP_ESC_EXT)
    |=> (state_reg == ST_SECOND))
    else $error("escape byte did not select a second op-code");

  wide_group_a: assert property (
    @(posedge I_CLK) disable iff (!I_RESET_N)
    (state_reg == ST_SECOND && I_BYTE_VALID && esc_reg == ESC_WIDE)
    |=> ##1 (O_DONE && O_WIDE_GROUP && O_INVALID))
    else $error("wide escape not reported");

  mode_bits_a: assert property (
    @(posedge I_CLK) disable iff (!I_RESET_N)
    (state_reg == ST_IDLE && I_BYTE_VALID && I_BYTE == 8'h4E)
    |=> ##1 (O_DONE && O_ADDR_MODE == MODE_IX1 && O_FORM == FORM_IND_IX1
             && O_CYCLES == CYC_IND && O_DEST == 2'h1))
    else $error("indirect mode not taken from low bits");

  no_operand_a: assert property (
    @(posedge I_CLK) disable iff (!I_RESET_N)
    (state_reg == ST_SECOND && I_BYTE_VALID && esc_reg == ESC_EXT
     && I_BYTE == 8'h43)
    |=> state_reg == ST_ISSUE ##1 (O_LEN == 3'h2 && O_CYCLES == CYC_LOW))
    else $error("index plus low form fetched an operand");

  high_byte_a: assert property (
    @(posedge I_CLK) disable iff (!I_RESET_N)
    (state_reg == ST_OPND2 && I_BYTE_VALID)
    |=> ##1 (O_DONE && O_OPERAND[15:8] == $past(I_BYTE, 2)))
    else $error("second operand byte not in high half");

  reg_load_a: assert property (
    @(posedge I_CLK) disable iff (!I_RESET_N)
    (state_reg == ST_IDLE && I_BYTE_VALID && I_BYTE == 8'h51)
    |=> ##1 (O_DONE && O_DEST == 2'h2 && O_SRC == 4'h1
             && O_CYCLES == CYC_REG && O_LEN == 3'h1))
    else $error("register load misdecoded");

  flags_kept_a: assert property (
    @(posedge I_CLK) disable iff (!I_RESET_N)
    O_DONE |-> !O_SC_WRITE && $stable(O_SC_WRITE))
    else $error("load wrote the condition flags");

  byte_order_a: assert property (
    @(posedge I_CLK) disable iff (!I_RESET_N)
    (take && state_reg != ST_IDLE) |=> O_PC_ADVANCE && count_reg >= 3'h2)
    else $error("byte not consumed in order");

  small_model_a: assert property (
    @(posedge I_CLK) disable iff (!I_RESET_N)
    (state_reg == ST_SECOND && I_BYTE_VALID && esc_reg == ESC_EXT
     && I_BYTE[7:2] == GRP_RD_PAGE && !I_LARGE_MODEL)
    |=> ##1 O_INVALID)
    else $error("page read accepted in a small model");

endmodule : tod_decoder

`default_nettype wire

// >>> tb/tod_fetch_model.sv
// Purpose : fetch unit model offering instruction bytes to the decoder
// Assumes : restarted by i_start for every instruction
// Notes   : slow mode leaves one idle cycle between bytes
`default_nettype none

module tod_fetch_model (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_start,
  input  wire logic        i_slow,
  input  wire logic [31:0] i_code,
  input  wire logic [2:0]  i_count,
  input  wire logic        i_ready,
  output logic             o_valid,
  output logic [7:0]       o_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] idx_reg;
  logic       more;
  logic [7:0] nxt;
  assign more = idx_reg < i_count;
  assign nxt  = i_code[8*idx_reg[1:0] +: 8];
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      idx_reg <= 3'h0;
      o_valid <= 1'b0;
      o_byte  <= 8'hA5;
    end else if (i_start) begin
      idx_reg <= 3'h1;
      o_valid <= 1'b1;
      o_byte  <= i_code[7:0];
    end else if (o_valid && i_ready) begin
      idx_reg <= (more && !i_slow) ? idx_reg + 3'h1 : idx_reg;
      o_valid <= more && !i_slow;
      o_byte  <= more ? (i_slow ? ~nxt : nxt) : ~o_byte;
    end else if (!o_valid && i_slow && more && idx_reg != 3'h0) begin
      idx_reg <= idx_reg + 3'h1;
      o_valid <= 1'b1;
      o_byte  <= nxt;
    end else if (!o_valid) begin
      o_byte <= ~o_byte;
    end
  end
endmodule : tod_fetch_model

`default_nettype wire

// >>> tb/testbench.sv
// Purpose : self-checking bench of the transfer op-code decoder
// Assumes : expectations come from a model written in the bench
// Notes   : reset between passes applies the next model and fetch speed
`default_nettype none

module testbench;
  import tod_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        I_CLK, I_RESET_N, lg, slow, start, fv, rdy, pca, done;
  logic        inv, wide, scw;
  logic [7:0]  bs, lw, gp, p1, p2, fb, pg;
  logic [15:0] pp, x1, x2, opnd;
  logic [31:0] code;
  logic [2:0]  cnt, mode, len, cyc;
  tod_form_t   form;
  logic [1:0]  dest;
  logic [3:0]  src;
  logic [23:0] ea;
  logic [15:0] tbl [34];
  int          bad_count, comparisons, seed;

  tod_fetch_model u_fetch (.i_clk(I_CLK), .i_reset_n(I_RESET_N),
    .i_start(start), .i_slow(slow), .i_code(code), .i_count(cnt),
    .i_ready(rdy), .o_valid(fv), .o_byte(fb));
  tod_decoder u_dut (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N),
    .I_BYTE_VALID(fv), .I_BYTE(fb), .I_LARGE_MODEL(lg), .I_BASE_REG(bs),
    .I_PTR_PAIR(pp), .I_INDEX1(x1), .I_INDEX2(x2), .I_LOW_DATA(lw),
    .I_GEN_PAGE(gp), .I_IDX1_PAGE(p1), .I_IDX2_PAGE(p2), .O_READY(rdy),
    .O_PC_ADVANCE(pca), .O_DONE(done), .O_INVALID(inv),
    .O_WIDE_GROUP(wide), .O_SC_WRITE(scw), .O_FORM(form), .O_DEST(dest),
    .O_SRC(src), .O_ADDR_MODE(mode), .O_LEN(len), .O_CYCLES(cyc),
    .O_OPERAND(opnd), .O_EA(ea));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [23:0] s, e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic run(input logic [15:0] t);
    logic [7:0]  b0, b1, b2, b3, d, xp;
    logic [15:0] xx, op;
    logic [23:0] e;
    logic [2:0]  ln, cy;
    logic [1:0]  ds;
    tod_form_t   f;
    logic        iv;
    int          k, np, nr;
    {b3, b2, b1, b0} = $random(seed);
    b0 = t[7:0];
    if (b0 == OP_ESC_EXT || b0 == OP_ESC_WIDE) b1 = t[15:8];
    @(posedge I_CLK);
    {bs, lw, gp, p1} <= $random(seed);
    {pp, x1} <= $random(seed);
    {p2, x2} <= 24'($random(seed));
    @(negedge I_CLK);
    f = FORM_NONE; ln = 1; cy = 0; op = 0; e = 0; iv = 1; ds = 0;
    pg = lg ? gp : 8'h00;
    if (b0[7:3] >= GRP_ROW_FIRST && b0[7:3] <= GRP_ROW_LAST) begin
      iv = 0; ds = b0[4:3]; cy = b0[2] ? 3'h2 : 3'h1; f = FORM_REG;
      case (b0[2:0])
        3'h4: begin f = FORM_ABS8; ln = 2; cy = 3; op = b1; e = {pg, bs, b1}; end
        3'h5: begin f = FORM_IND_PTR; e = {pg, pp}; end
        3'h6: begin f = FORM_IND_IX1; e = {lg ? p1 : 8'h00, x1}; end
        3'h7: begin f = FORM_IND_IX2; e = {lg ? p2 : 8'h00, x2}; end
        default: ;
      endcase
    end else if (b0 >= 8'hB0 && b0 <= 8'hB2) begin
      iv = 0; f = FORM_IMM8; ds = b0[1:0]; ln = 2; cy = 2; op = b1;
    end else if (b0 == OP_ABS8_IMM) begin
      iv = 0; f = FORM_ABS8_IMM; ds = DEST_MEM; ln = 3; cy = 4;
      op = {b2, b1}; e = {pg, bs, b1};
    end else if (b0 == OP_ESC_EXT || b0 == OP_ESC_WIDE) begin
      ln = 2;
      if (b0 == OP_ESC_WIDE) ;
      else if (b1[7:3] >= 5'h08 && b1[7:3] <= 5'h0A && !b1[2]) begin
        iv = 0; ds = b1[4:3]; cy = 4; ln = b1[1] ? 3'h2 : 3'h3;
        f = tod_form_t'(4'h9 + b1[1:0]);
        d = b1[1] ? lw : b2; op = b1[1] ? 16'h0 : {8'h00, b2};
        xx = b1[0] ? x2 : x1; xp = b1[0] ? p2 : p1;
        e = {lg ? xp : 8'h00, xx + {{8{d[7]}}, d}};
      end else if (b1 >= 8'hD0 && b1 <= 8'hD2) begin
        iv = 0; f = FORM_ABS16; ds = b1[1:0]; ln = 4; cy = 5;
        op = {b3, b2}; e = {pg, b3, b2};
      end else if (b1 == 8'hC0 || b1 == 8'hC1 || (lg && b1[7:2] == 6'h32))
      begin
        iv = 0; f = FORM_SYSREG; cy = 2;
      end
    end
    @(posedge I_CLK);
    code <= {b3, b2, b1, b0}; cnt <= ln; start <= 1'b1;
    @(posedge I_CLK);
    start <= 1'b0;
    k = 0; np = 0; nr = 0;
    do begin
      @(negedge I_CLK);
      k++;
      if (pca === 1'b1) np++;
      if (rdy === 1'b0) nr++;
    end while (done !== 1'b1 && k < 16);
    // ready must fall for exactly the one issue cycle
    chk("ready drops", 24'(nr), 24'h1);
    chk("done", done, 1'b1);
    chk("invalid", inv, iv);
    chk("wide", wide, b0 == OP_ESC_WIDE);
    chk("flag write", scw, 1'b0);
    chk("form", form, f);
    chk("cycles", cyc, cy);
    if (b0 != OP_ESC_WIDE) begin
      chk("length", len, ln);
      chk("advances", 24'(np), ln);
      chk("latency", 24'(k), 24'(slow ? 2 * ln + 1 : ln + 2));
    end
    if (!iv) begin
      chk("dest", dest, ds);
      chk("mode", mode, b0 == OP_ESC_EXT ? b1[2:0] : b0[2:0]);
      chk("operand", opnd, op);
      chk("address", ea, e);
    end
    if (f == FORM_REG) chk("source", src, b0[1:0]);
    if (f == FORM_SYSREG) chk("source", src, b1[3:0]);
  endtask : run

  ////////////////////////////////////////////////////////////////////////
  initial begin
    I_CLK = 1'b0;
    forever #25 I_CLK = ~I_CLK;
  end

  initial begin
    #(6000 * 50);
    bad_count++;
    report_and_stop;
  end

  initial begin
    seed = 32'h53c6; bad_count = 0; comparisons = 0;
    I_RESET_N = 1'b0; lg = 0; slow = 0; start = 0; code = 0; cnt = 1;
    bs = 0; lw = 0; gp = 0; p1 = 0; p2 = 0; pp = 0; x1 = 0; x2 = 0;
    tbl = '{16'h0040, 16'h0043, 16'h0049, 16'h0052, 16'h00B0, 16'h00B1,
      16'h00B2, 16'h0044, 16'h004C, 16'h0054, 16'h0045, 16'h004E, 16'h0057,
      16'h00DD, 16'h40CE, 16'h49CE, 16'h50CE, 16'h42CE, 16'h4BCE, 16'h53CE,
      16'hD0CE, 16'hD1CE, 16'hD2CE, 16'hC0CE, 16'hC1CE, 16'hC8CE, 16'hC9CE,
      16'hCACE, 16'hCBCE, 16'h0000, 16'h0060, 16'hE0CF, 16'h0051, 16'h43CE};
    for (int p = 0; p < 4; p++) begin
      @(posedge I_CLK);
      I_RESET_N <= 1'b0;
      repeat (4) @(posedge I_CLK);
      I_RESET_N <= 1'b1; lg <= p[0]; slow <= p[1];
      foreach (tbl[i]) run(tbl[i]);
      $display("test pass %0d done", p);
    end
    report_and_stop;
  end
endmodule : testbench

`default_nettype wire
